// ==== logic/qadc_timing_map.vh ====
// constants for the quad converter conversion and read-out logic
`ifndef QADC_TIMING_MAP_VH
`define QADC_TIMING_MAP_VH

`define QADC_CLK_PERIOD_NS 8
`define QADC_T_CONV0_MAX_NS 10
`define QADC_T_OSX_16B_NS 320
`define QADC_T_OSX_14B_NS 250
`define QADC_T_ALERT_SET_MAX_NS 220
`define QADC_T_ALERT_OVS_MAX_NS 20
`define QADC_RESULT_BITS 16
`define QADC_CMD_BITS 16
`define QADC_CMD_CNT_BITS 5
`define QADC_OSR_SEL_BITS 2
`define QADC_ACC_EXTRA_BITS 3
`define QADC_RST_ALERT_N 1'b1
`define QADC_RST_LANE 1'b0

`endif

// ==== logic/qadc_pin_sync.v ====
// two-stage synchroniser with registered level and edge flags
`timescale 1ns/1ps
module qadc_pin_sync #(
	parameter W = 3,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input wire i_sys_clk, // system clock
	input wire i_rst_n, // synchronous reset, active low
	input wire [W-1:0] i_pin, // asynchronous pin levels
	output reg [W-1:0] o_level, // synchronised level
	output reg [W-1:0] o_rise, // one-cycle pulse on rising edge
	output reg [W-1:0] o_fall // one-cycle pulse on falling edge
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
			o_level <= RST_VAL;
			o_rise <= {W{1'b0}};
			o_fall <= {W{1'b0}};
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			o_level <= sync_q;
			o_rise <= sync_q & ~o_level;
			o_fall <= ~sync_q & o_level;
		end
	end
endmodule

// ==== logic/qadc_conv_ctrl.v ====
// conversion sequencing, oversampling, serial read-out and out-of-range flag
//
// Contract
// - first oversampled conversion done within 10 ns
// - xth sample adds 320 or 250 ns steps
// - lanes leave high impedance on select low
// - lanes return high impedance on select high
// - lane data changes after clock rising edges
// - serial input sampled on clock falling edges
// - flag asserted within 220 ns of select
// - flag cleared by next select event
// - oversampling flag set per exceeding internal conversion
`timescale 1ns/1ps
`include "qadc_timing_map.vh"
module qadc_conv_ctrl #(
	parameter DW = `QADC_RESULT_BITS,
	parameter RES16 = 1
) (
	input wire i_sys_clk, // system clock, 125 MHz
	input wire i_rst_n, // synchronous reset, active low, also hard reset
	input wire i_cs_n, // chip select pin, active low
	input wire i_sclk, // serial clock pin
	input wire i_serial_command_in, // serial command input pin
	input wire [DW-1:0] i_sample_a, // channel a sample, two's complement
	input wire [DW-1:0] i_sample_b, // channel b sample, two's complement
	input wire [DW-1:0] i_alert_high, // out-of-range threshold, signed
	input wire [`QADC_OSR_SEL_BITS-1:0] i_oversampling_log2, // 0 none, n gives 2^n samples
	output reg o_result_lane_a, // lane a serial data
	output reg o_result_lane_a_oe, // lane a drive enable
	output reg o_result_lane_b, // lane b serial data
	output reg o_result_lane_b_oe, // lane b drive enable
	output reg o_alert_n, // out-of-range flag, active low
	output reg [`QADC_CMD_BITS-1:0] o_cmd_word, // last whole command word
	output reg o_cmd_valid, // pulse on select rise after a whole command word
	output reg o_busy // conversion in progress
);
	localparam AW = DW + `QADC_ACC_EXTRA_BITS;
	localparam ST_IDLE = 1'b0;
	localparam ST_CONV = 1'b1;
	localparam CW = 8;
	localparam [CW-1:0] CONV0_CYC = cyc_max(`QADC_T_CONV0_MAX_NS);
	localparam [CW-1:0] OSX_CYC = RES16 ? cyc_max(`QADC_T_OSX_16B_NS) :
		cyc_max(`QADC_T_OSX_14B_NS);

	// longest time to whole cycles, rounded down, never below one
	function [CW-1:0] cyc_max;
		input integer ns;
		integer c;
		begin
			c = ns / `QADC_CLK_PERIOD_NS;
			if (c < 1)
				c = 1;
			cyc_max = c[CW-1:0];
		end
	endfunction

	function [AW-1:0] sext;
		input [DW-1:0] v;
		begin
			sext = {{(AW-DW){v[DW-1]}}, v};
		end
	endfunction

	function over_thr;
		input [DW-1:0] v;
		input [DW-1:0] thr;
		begin
			over_thr = $signed(v) > $signed(thr);
		end
	endfunction

	wire [2:0] pin_level;
	wire [2:0] pin_rise;
	wire [2:0] pin_fall;

	qadc_pin_sync #(
		.W(3),
		.RST_VAL(3'b001)
	) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_pin({i_serial_command_in, i_sclk, i_cs_n}),
		.o_level(pin_level),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	wire cs_low = ~pin_level[0];
	wire cs_fall = pin_fall[0];
	wire cs_rise = pin_rise[0];
	wire sclk_rise = pin_rise[1];
	wire sclk_fall = pin_fall[1];
	wire cmd_bit = pin_level[2];

	reg state_q;
	reg [CW-1:0] cnt_q;
	reg [3:0] idx_q;
	reg [3:0] n_q;
	reg [`QADC_OSR_SEL_BITS-1:0] shift_q;
	reg [AW-1:0] acc_a_q;
	reg [AW-1:0] acc_b_q;
	reg [DW-1:0] res_a_q;
	reg [DW-1:0] res_b_q;
	reg [DW-1:0] sh_a_q;
	reg [DW-1:0] sh_b_q;
	reg [`QADC_CMD_BITS-1:0] cmd_sh_q;
	reg [`QADC_CMD_CNT_BITS-1:0] cmd_cnt_q;

	wire sample_tick = (state_q == ST_CONV) && (cnt_q == {{(CW-1){1'b0}}, 1'b1});
	wire last_sample = (idx_q + 4'h1) == n_q;
	wire [AW-1:0] sum_a = acc_a_q + sext(i_sample_a);
	wire [AW-1:0] sum_b = acc_b_q + sext(i_sample_b);
	wire [AW-1:0] avg_a = $signed(sum_a) >>> shift_q;
	wire [AW-1:0] avg_b = $signed(sum_b) >>> shift_q;
	wire hit = sample_tick &&
		(over_thr(i_sample_a, i_alert_high) || over_thr(i_sample_b, i_alert_high));

	// conversion sequencer
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
			cnt_q <= {CW{1'b0}};
			idx_q <= 4'h0;
			n_q <= 4'h1;
			shift_q <= {`QADC_OSR_SEL_BITS{1'b0}};
			acc_a_q <= {AW{1'b0}};
			acc_b_q <= {AW{1'b0}};
			res_a_q <= {DW{1'b0}};
			res_b_q <= {DW{1'b0}};
			o_busy <= 1'b0;
		end else begin
			if (cs_fall) begin
				state_q <= ST_CONV;
				cnt_q <= CONV0_CYC;
				idx_q <= 4'h0;
				n_q <= 4'h1 << i_oversampling_log2;
				shift_q <= i_oversampling_log2;
				acc_a_q <= {AW{1'b0}};
				acc_b_q <= {AW{1'b0}};
				o_busy <= 1'b1;
			end else if (state_q == ST_CONV) begin
				cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
				if (sample_tick) begin
					acc_a_q <= sum_a;
					acc_b_q <= sum_b;
					idx_q <= idx_q + 4'h1;
					if (last_sample) begin
						res_a_q <= avg_a[DW-1:0];
						res_b_q <= avg_b[DW-1:0];
						state_q <= ST_IDLE;
						o_busy <= 1'b0;
					end else begin
						cnt_q <= OSX_CYC;
					end
				end
			end
		end
	end

	// out-of-range flag; a hit in the clearing cycle keeps it set
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_alert_n <= `QADC_RST_ALERT_N;
		end else if (hit) begin
			o_alert_n <= 1'b0;
		end else if (cs_fall) begin
			o_alert_n <= 1'b1;
		end
	end

	// result lanes: previous result, msb first
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			sh_a_q <= {DW{1'b0}};
			sh_b_q <= {DW{1'b0}};
			o_result_lane_a <= `QADC_RST_LANE;
			o_result_lane_b <= `QADC_RST_LANE;
			o_result_lane_a_oe <= 1'b0;
			o_result_lane_b_oe <= 1'b0;
		end else begin
			o_result_lane_a_oe <= cs_low;
			o_result_lane_b_oe <= cs_low;
			if (cs_fall) begin
				sh_a_q <= {res_a_q[DW-2:0], 1'b0};
				sh_b_q <= {res_b_q[DW-2:0], 1'b0};
				o_result_lane_a <= res_a_q[DW-1];
				o_result_lane_b <= res_b_q[DW-1];
			end else if (cs_low && sclk_rise) begin
				sh_a_q <= {sh_a_q[DW-2:0], 1'b0};
				sh_b_q <= {sh_b_q[DW-2:0], 1'b0};
				o_result_lane_a <= sh_a_q[DW-1];
				o_result_lane_b <= sh_b_q[DW-1];
			end
		end
	end

	// command input, taken on falling serial clock
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cmd_sh_q <= {`QADC_CMD_BITS{1'b0}};
			cmd_cnt_q <= {`QADC_CMD_CNT_BITS{1'b0}};
			o_cmd_word <= {`QADC_CMD_BITS{1'b0}};
			o_cmd_valid <= 1'b0;
		end else begin
			o_cmd_valid <= 1'b0;
			if (cs_fall) begin
				cmd_cnt_q <= {`QADC_CMD_CNT_BITS{1'b0}};
			end else if (cs_low && sclk_fall) begin
				cmd_sh_q <= {cmd_sh_q[`QADC_CMD_BITS-2:0], cmd_bit};
				if (cmd_cnt_q != `QADC_CMD_BITS)
					cmd_cnt_q <= cmd_cnt_q + {{(`QADC_CMD_CNT_BITS-1){1'b0}}, 1'b1};
			end else if (cs_rise && cmd_cnt_q == `QADC_CMD_BITS) begin
				o_cmd_word <= cmd_sh_q;
				o_cmd_valid <= 1'b1;
			end
		end
	end
endmodule

// ==== bench/qadc_conv_monitor.sv ====
// checker for conversion and read-out timing
`timescale 1ns/1ps
module qadc_conv_monitor #(
	parameter RES16 = 1
) (
	input wire i_sys_clk, // clock
	input wire i_rst_n, // reset
	input wire i_cs_n, // select
	input wire i_sclk, // link clock
	input wire [15:0] i_sample_a, // sample a
	input wire [15:0] i_sample_b, // sample b
	input wire [15:0] i_alert_high, // threshold
	input wire [1:0] i_oversampling_log2, // ratio
	input wire o_result_lane_a, // lane a
	input wire o_result_lane_a_oe, // enable a
	input wire o_result_lane_b, // lane b
	input wire o_result_lane_b_oe, // enable b
	input wire o_alert_n, // flag
	input wire o_cmd_valid, // command pulse
	input wire o_busy // converting
);
	reg [8:0] len_q;
	wire hit_a = $signed(i_sample_a) > $signed(i_alert_high);
	wire hit_b = $signed(i_sample_b) > $signed(i_alert_high);
	wire hit = hit_a || hit_b;
	wire [8:0] step = RES16 ? 9'h028 : 9'h01F;
	wire [8:0] exp_len = step * ((9'h001 << i_oversampling_log2) - 9'h001) + 9'h001;
	always @(posedge i_sys_clk) len_q <= (o_busy && i_rst_n) ? len_q + 9'h001 : 9'h000;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	chk_lane_enable: assert property ($fell(i_cs_n) |-> ##[4:5] o_result_lane_a_oe && o_result_lane_b_oe)
		else $error("lanes not enabled");
	chk_lane_release: assert property ($rose(i_cs_n) |-> ##[4:5] !o_result_lane_a_oe && !o_result_lane_b_oe)
		else $error("lanes not released");
	chk_lane_hold: assert property ($fell(i_sclk) |=> ($stable(o_result_lane_a) && $stable(o_result_lane_b)) [*6])
		else $error("lane changed while clock low");
	chk_alert_set: assert property ($fell(i_cs_n) && hit |-> ##[1:27] !o_alert_n)
		else $error("flag late");
	chk_alert_clear: assert property ($fell(i_cs_n) && !hit |-> ##[4:6] o_alert_n)
		else $error("flag not cleared");
	chk_alert_os: assert property ($fell(o_busy) && hit |-> ##[0:2] !o_alert_n)
		else $error("flag late after conversion");
	chk_conv_len: assert property ($fell(o_busy) |-> len_q + 9'h001 >= exp_len && len_q <= exp_len + 9'h001)
		else $error("conversion length wrong");
	chk_cmd_pulse: assert property (o_cmd_valid |-> i_cs_n ##1 !o_cmd_valid)
		else $error("command pulse wrong");
	cover property ($fell(o_alert_n));
	cover property (o_cmd_valid);
	cover property ($fell(o_busy) && i_oversampling_log2 == 2'h3);
endmodule
bind qadc_conv_ctrl qadc_conv_monitor #(.RES16(RES16)) qadc_conv_monitor_i (.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_sample_a(i_sample_a),
	.i_sample_b(i_sample_b), .i_alert_high(i_alert_high),
	.i_oversampling_log2(i_oversampling_log2),
	.o_result_lane_a(o_result_lane_a), .o_result_lane_a_oe(o_result_lane_a_oe),
	.o_result_lane_b(o_result_lane_b), .o_result_lane_b_oe(o_result_lane_b_oe),
	.o_alert_n(o_alert_n), .o_cmd_valid(o_cmd_valid), .o_busy(o_busy));

// ==== bench/qadc_host.sv ====
// host model driving select, link clock and command line
`timescale 1ns/1ps
module qadc_host (
	output reg o_cs_n, // select, active low
	output reg o_sclk, // link clock, idle low
	output reg o_cmd_bit, // command bit
	input wire i_lane_a, // lane a
	input wire i_lane_b // lane b
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_cmd_bit = 1'b0;
	end
	task frame(input [15:0] cmd, output [15:0] ra, output [15:0] rb);
		integer k;
		begin
			#300 o_cs_n = 1'b0;
			for (k = 0; k < 16; k = k + 1) begin
				#62.5 o_sclk = 1'b1;
				ra = {ra[14:0], i_lane_a};
				rb = {rb[14:0], i_lane_b};
				#31 o_cmd_bit = cmd[15 - k];
				#31.5 o_sclk = 1'b0;
			end
			#62.5 o_cs_n = 1'b1;
			o_cmd_bit = ~o_cmd_bit;
		end
	endtask
endmodule

// ==== bench/tb_quad_adc_conversion_timing.sv ====
// self-checking bench for the conversion and read-out block
`timescale 1ns/1ps
module tb_quad_adc_conversion_timing;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [15:0] sa = 16'h0000;
	reg [15:0] sb = 16'h0000;
	reg [15:0] thr = 16'h7FFF;
	reg [1:0] ratio = 2'h0;
	wire cs_n, sclk, cmd_in, la, la_oe, lb, lb_oe, alert_n, cmd_valid, busy;
	// a released lane shows the host the inverse of its last bit
	wire la_pin = la_oe ? la : ~la;
	wire lb_pin = lb_oe ? lb : ~lb;
	wire [15:0] cmd_word;
	integer fails = 0;
	integer checked = 0;
	always #4 clk = ~clk;
	qadc_conv_ctrl qadc_conv_ctrl_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_serial_command_in(cmd_in), .i_sample_a(sa), .i_sample_b(sb),
		.i_alert_high(thr), .i_oversampling_log2(ratio), .o_result_lane_a(la),
		.o_result_lane_a_oe(la_oe), .o_result_lane_b(lb), .o_result_lane_b_oe(lb_oe),
		.o_alert_n(alert_n), .o_cmd_word(cmd_word), .o_cmd_valid(cmd_valid), .o_busy(busy));
	qadc_host qadc_host_i (.o_cs_n(cs_n), .o_sclk(sclk), .o_cmd_bit(cmd_in),
		.i_lane_a(la_pin), .i_lane_b(lb_pin));
	task finish_test;
		begin
			if (fails == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input string name, input [15:0] exp, input [15:0] got);
		begin
			checked = checked + 1;
			if (exp !== got) begin
				$display("ERROR %s expected %h seen %h", name, exp, got);
				fails = fails + 1;
			end
		end
	endtask
	task setin(input [15:0] a, input [15:0] b, input [15:0] t, input [1:0] o);
		begin
			@(posedge clk);
			#1;
			sa = a;
			sb = b;
			thr = t;
			ratio = o;
		end
	endtask
	task xfer(input [15:0] cmd, input [15:0] ea, input [15:0] eb);
		reg [15:0] ra, rb;
		integer k;
		begin
			qadc_host_i.frame(cmd, ra, rb);
			chk("lane a", ea, ra);
			chk("lane b", eb, rb);
			for (k = 0; k < 400 && busy !== 1'b0; k = k + 1) begin
				@(posedge clk);
				#1;
			end
			if (k == 400) begin
				$display("ERROR busy expected 0 seen %b", busy);
				fails = fails + 1;
				finish_test;
			end
		end
	endtask
	task t_readout;
		integer k;
		begin
			setin(16'h1234, 16'hF0F0, 16'h7FFF, 2'h0);
			xfer(16'hA5C3, 16'h0000, 16'h0000);
			for (k = 0; k < 20 && cmd_valid !== 1'b1; k = k + 1) begin
				@(posedge clk);
				#1;
			end
			chk("cmd seen", 16'h0001, {15'h0, cmd_valid});
			chk("cmd word", 16'hA5C3, cmd_word);
			repeat (4) @(posedge clk);
			chk("lane enable", 16'h0000, {14'h0, la_oe, lb_oe});
		end
	endtask
	task t_oversample;
		begin
			setin(16'hFFFE, 16'h0003, 16'h7FFF, 2'h2);
			xfer(16'h0001, 16'h1234, 16'hF0F0);
			setin(16'hFFFA, 16'h0003, 16'h7FFF, 2'h3);
			xfer(16'h0002, 16'hFFFE, 16'h0003);
		end
	endtask
	task t_alert;
		begin
			setin(16'h0200, 16'h0000, 16'h0100, 2'h0);
			xfer(16'h0003, 16'hFFFA, 16'h0003);
			chk("alert set", 16'h0000, {15'h0, alert_n});
			setin(16'h0010, 16'h0000, 16'h0100, 2'h1);
			xfer(16'h0004, 16'h0200, 16'h0000);
			chk("alert clear", 16'h0001, {15'h0, alert_n});
		end
	endtask
	task t_reset;
		begin
			setin(16'h0200, 16'h0000, 16'h0100, 2'h0);
			xfer(16'h0005, 16'h0010, 16'h0000);
			chk("alert before reset", 16'h0000, {15'h0, alert_n});
			@(posedge clk);
			#1;
			rst_n = 1'b0;
			repeat (5) @(posedge clk);
			#1;
			chk("reset flags", 16'h0010, {11'h0, alert_n, busy, la_oe, lb_oe, cmd_valid});
			chk("reset cmd word", 16'h0000, cmd_word);
			rst_n = 1'b1;
			repeat (100) @(posedge clk);
			setin(16'h1111, 16'h2222, 16'h7FFF, 2'h0);
			xfer(16'h0006, 16'h0000, 16'h0000);
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		// no supply or shutdown model: reset release stands for supply up
		repeat (100) @(posedge clk);
		t_readout;
		t_oversample;
		t_alert;
		t_reset;
		finish_test;
	end
endmodule
